// File: logic/source_qualification_monitor.v
// What this block does
// - undervoltage persisting for delay requests transfer, recovery retransfer
// - undervoltage dropout 75-98% of pickup, default 90
// - undervoltage pickup 85-100% of nominal, default 90
// - undervoltage delay 0.1-1.0 s, default 0.5
// - overvoltage persisting requests transfer, recovery retransfer
// - overvoltage dropout 105-135% nominal, default 110
// - overvoltage pickup 95-100% of dropout, default 95
// - overvoltage delay 0.5-120 s, default 3.0
// - overvoltage per-source disable, enabled after reset
// - nominal frequency 45.0-60.0 Hz, default 60
// - frequency pickup band 5-20%, default 10
// - frequency dropout 1-5% beyond band, default 1
// - frequency fault after delay 0.1-15 s
// - frequency per-source disable, enabled after reset
// - three-phase imbalance fails beyond 2-10% setting
// - imbalance pickup 10% of dropout, delay 2-20 s
// - single phase: imbalance never fails
// - differing rotation inhibits transfer
// - rotation judged only with both sources present
// - rotation check disable, enabled after reset
// - reduced level three-phase source 2 never available
`timescale 1ns/1ps
`include "srcq_defs.vh"
`default_nettype none
module source_qualification_monitor #(
  parameter TICK_COUNT = `TICK_CYCLES,
  parameter VW = 16,
  parameter FW = 10
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // register port
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // measurements, source 1 then source 2 (three phases each)
  input wire [3*VW-1:0] volt1,
  input wire [3*VW-1:0] volt2,
  input wire [FW-1:0] freq1,
  input wire [FW-1:0] freq2,
  input wire present1,
  input wire present2,
  input wire rot1,
  input wire rot2,
  input wire meas_valid,
  input wire connected2,
  // results
  output reg avail1,
  output reg avail2,
  output reg xfer_req,
  output reg rexfer_req,
  output reg xfer_inhibit,
  output reg imb_fail1,
  output reg imb_fail2
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function [7:0] clamp8;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // value * pct / 100 with generous width
  function [31:0] pct_of;
    input [31:0] v;
    input [7:0] p;
    begin
      pct_of = (v * {24'h000000, p}) / 32'd100;
    end
  endfunction

  function [VW-1:0] avg3;
    input [3*VW-1:0] v;
    reg [VW+1:0] q;
    begin
      q = ({2'b00, v[VW-1:0]} + {2'b00, v[2*VW-1:VW]} + {2'b00, v[3*VW-1:2*VW]})
        / {{VW{1'b0}}, 2'b11};
      avg3 = q[VW-1:0]; // the mean of three words always fits one word
    end
  endfunction

  function [VW-1:0] absd;
    input [VW-1:0] a;
    input [VW-1:0] b;
    begin
      absd = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  function [VW-1:0] maxdev;
    input [3*VW-1:0] v;
    reg [VW-1:0] m;
    reg [VW-1:0] d0;
    reg [VW-1:0] d1;
    reg [VW-1:0] d2;
    begin
      m = avg3(v);
      d0 = absd(v[VW-1:0], m);
      d1 = absd(v[2*VW-1:VW], m);
      d2 = absd(v[3*VW-1:2*VW], m);
      maxdev = (d0 > d1) ? ((d0 > d2) ? d0 : d2) : ((d1 > d2) ? d1 : d2);
    end
  endfunction

  // one sensor step: timed drop-out, prompt pick-up, fault latched between
  function [11:0] sense_step;
    input en;
    input bad;
    input [10:0] t;
    input fail_c;
    input pick_c;
    input [10:0] dly;
    input tk;
    begin
      if (!en)
        sense_step = 12'h000;
      else if (bad)
        sense_step = pick_c ? 12'h000 : {1'b1, t};
      else if (!fail_c)
        sense_step = 12'h000;
      else if (t >= dly)
        sense_step = {1'b1, 11'h000};
      else
        sense_step = {1'b0, t + {10'h000, tk}};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // settings registers
  reg [7:0] ctrl;
  reg [7:0] uv_drop, uv_pick, uv_dly;
  reg [7:0] ov_drop, ov_pick;
  reg [10:0] ov_dly;
  reg [9:0] nom_f;
  reg [7:0] f_band, f_drop, f_dly;
  reg [7:0] imb_drop, imb_dly;
  reg [VW-1:0] nom_v;

  // writes clamp every setting except ctrl and nom_v into its legal range
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl <= `CTRL_RESET;
      uv_drop <= `UV_DROP_RST;
      uv_pick <= `UV_PICK_RST;
      uv_dly <= `UV_DLY_RST;
      ov_drop <= `OV_DROP_RST;
      ov_pick <= `OV_PICK_RST;
      ov_dly <= `OV_DLY_RST;
      nom_f <= `NOMF_RST;
      f_band <= `FBAND_RST;
      f_drop <= `FDROP_RST;
      f_dly <= `FDLY_RST;
      imb_drop <= `IMB_DROP_RST;
      imb_dly <= `IMB_DLY_RST;
      nom_v <= `NOMV_RST;
    end
    else if (wr)
    begin
      if (addr == `REG_CTRL)
        ctrl <= wdata[7:0];
      else if (addr == `REG_UV)
      begin
        uv_drop <= clamp8(wdata[7:0], `UV_DROP_MIN, `UV_DROP_MAX);
        uv_pick <= clamp8(wdata[15:8], `UV_PICK_MIN, `UV_PICK_MAX);
        uv_dly <= clamp8(wdata[23:16], `UV_DLY_MIN, `UV_DLY_MAX);
      end
      else if (addr == `REG_OV)
      begin
        ov_drop <= clamp8(wdata[7:0], `OV_DROP_MIN, `OV_DROP_MAX);
        ov_pick <= clamp8(wdata[15:8], `OV_PICK_MIN, `OV_PICK_MAX);
        ov_dly <= (wdata[26:16] < `OV_DLY_MIN) ? `OV_DLY_MIN :
          ((wdata[26:16] > `OV_DLY_MAX) ? `OV_DLY_MAX : wdata[26:16]);
      end
      else if (addr == `REG_FREQ)
      begin
        nom_f <= (wdata[9:0] < `NOMF_MIN) ? `NOMF_MIN :
          ((wdata[9:0] > `NOMF_MAX) ? `NOMF_MAX : wdata[9:0]);
        f_band <= clamp8({3'b000, wdata[14:10]}, `FBAND_MIN, `FBAND_MAX);
        f_drop <= clamp8({5'b00000, wdata[17:15]}, `FDROP_MIN, `FDROP_MAX);
        f_dly <= clamp8(wdata[25:18], `FDLY_MIN, `FDLY_MAX);
      end
      else if (addr == `REG_IMB)
      begin
        imb_drop <= clamp8(wdata[7:0], `IMB_DROP_MIN, `IMB_DROP_MAX);
        imb_dly <= clamp8(wdata[15:8], `IMB_DLY_MIN, `IMB_DLY_MAX);
      end
      else if (addr == `REG_NOMV)
        nom_v <= wdata[VW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 0.1 s tick divider
  reg [31:0] tick_cnt;
  reg tick;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end
    else if (tick_cnt >= TICK_COUNT - 1)
    begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // a tick between fresh samples waits for the next one; else a slow front end stretches delays
  reg tick_pend;

  always @(posedge mclk)
  begin
    if (rst)
      tick_pend <= 1'b0;
    else if (meas_valid)
      tick_pend <= 1'b0;
    else if (tick)
      tick_pend <= 1'b1;
  end
  wire tick_due = tick | tick_pend;

  ////////////////////////////////////////////////////////////////////////
  // thresholds shared by both sources
  wire [31:0] uv_pick_v = pct_of({16'h0000, nom_v}, uv_pick);
  wire [31:0] uv_drop_v = pct_of(uv_pick_v, uv_drop);
  wire [31:0] ov_drop_v = pct_of({16'h0000, nom_v}, ov_drop);
  wire [31:0] ov_pick_v = pct_of(ov_drop_v, ov_pick);
  wire [31:0] f_pick_d = pct_of({22'h000000, nom_f}, f_band);
  wire [31:0] f_drop_d = pct_of({22'h000000, nom_f}, f_band + f_drop);
  wire [31:0] f_lo_pick = {22'h000000, nom_f} - f_pick_d;
  wire [31:0] f_hi_pick = {22'h000000, nom_f} + f_pick_d;
  wire [31:0] f_lo_drop = {22'h000000, nom_f} - f_drop_d;
  wire [31:0] f_hi_drop = {22'h000000, nom_f} + f_drop_d;

  ////////////////////////////////////////////////////////////////////////
  // per-source sensors; index 0 is source 1
  reg [1:0] uv_bad, ov_bad, fq_bad, imb_bad;
  reg [10:0] uv_t [0:1];
  reg [10:0] ov_t [0:1];
  reg [10:0] fq_t [0:1];
  reg [10:0] imb_t [0:1];
  wire [3*VW-1:0] vv [0:1];
  wire [FW-1:0] ff [0:1];
  wire [1:0] three;
  assign vv[0] = volt1;
  assign vv[1] = volt2;
  assign ff[0] = freq1;
  assign ff[1] = freq2;
  assign three = {ctrl[`CTRL_THREE2], ctrl[`CTRL_THREE1]};
  // imbalance delay is in seconds: ten ticks each
  wire [10:0] imb_dly_t = {3'b000, imb_dly[4:0], 3'b000} + {3'b000, imb_dly[6:0], 1'b0};

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1)
    begin : sens
      // lowest and highest phase drive the voltage windows
      wire [VW-1:0] p0 = vv[s][VW-1:0];
      wire [VW-1:0] p1 = three[s] ? vv[s][2*VW-1:VW] : p0;
      wire [VW-1:0] p2 = three[s] ? vv[s][3*VW-1:2*VW] : p0;
      wire [VW-1:0] vmin = (p0 < p1) ? ((p0 < p2) ? p0 : p2) : ((p1 < p2) ? p1 : p2);
      wire [VW-1:0] vmax = (p0 > p1) ? ((p0 > p2) ? p0 : p2) : ((p1 > p2) ? p1 : p2);
      wire [31:0] v_lo = {16'h0000, vmin};
      wire [31:0] v_hi = {16'h0000, vmax};
      wire [31:0] fr = {22'h000000, ff[s]};
      wire [31:0] avg_v = {16'h0000, avg3(vv[s])};
      wire [31:0] dev = {16'h0000, maxdev(vv[s])};
      wire [31:0] imb_lim = pct_of(avg_v, imb_drop);
      wire [31:0] imb_pk = pct_of(imb_lim, 8'd10);
      wire ov_en = ctrl[`CTRL_OV_EN1 + s];
      wire fq_en = ctrl[`CTRL_FQ_EN1 + s];

      // sensors step only on a fresh measurement
      always @(posedge mclk)
      begin
        if (rst)
        begin
          uv_bad[s] <= 1'b0;
          ov_bad[s] <= 1'b0;
          fq_bad[s] <= 1'b0;
          imb_bad[s] <= 1'b0;
          uv_t[s] <= 11'h000;
          ov_t[s] <= 11'h000;
          fq_t[s] <= 11'h000;
          imb_t[s] <= 11'h000;
        end
        else if (meas_valid)
        begin
          // under-voltage: lowest phase against the timed drop-out
          {uv_bad[s], uv_t[s]} <= sense_step(1'b1, uv_bad[s], uv_t[s], v_lo < uv_drop_v,
            v_lo >= uv_pick_v, {3'b000, uv_dly}, tick_due);
          // over-voltage: highest phase; switched off clears the sensor
          {ov_bad[s], ov_t[s]} <= sense_step(ov_en, ov_bad[s], ov_t[s], v_hi > ov_drop_v,
            v_hi <= ov_pick_v, ov_dly, tick_due);
          // frequency: drop-out limits lie outside the pick-up band
          {fq_bad[s], fq_t[s]} <= sense_step(fq_en, fq_bad[s], fq_t[s],
            fr < f_lo_drop || fr > f_hi_drop, fr >= f_lo_pick && fr <= f_hi_pick,
            {3'b000, f_dly}, tick_due);
          // imbalance, three-phase only
          {imb_bad[s], imb_t[s]} <= sense_step(three[s], imb_bad[s], imb_t[s], dev > imb_lim,
            dev <= imb_pk, imb_dly_t, tick_due);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // results and transfer decisions
  wire [1:0] good = ~(uv_bad | ov_bad | fq_bad) & {present2, present1};
  // reduced level cannot sense three phases on source 2
  wire s2_blocked = ~ctrl[`CTRL_FULL] & ctrl[`CTRL_THREE2];
  wire ok1 = good[0];
  wire ok2 = good[1] & ~s2_blocked;
  // rotation only compared with both sources measured
  wire rot_bad = ctrl[`CTRL_ROT_EN] & present1 & present2 & meas_valid
    & (rot1 != rot2);

  always @(posedge mclk)
  begin
    if (rst)
    begin
      avail1 <= 1'b0;
      avail2 <= 1'b0;
      xfer_req <= 1'b0;
      rexfer_req <= 1'b0;
      xfer_inhibit <= 1'b0;
      imb_fail1 <= 1'b0;
      imb_fail2 <= 1'b0;
    end
    else
    begin
      avail1 <= ok1;
      avail2 <= ok2;
      // transfer away from a failed source 1, back once it is good
      xfer_req <= ~ok1 & ~connected2;
      rexfer_req <= ok1 & connected2;
      xfer_inhibit <= rot_bad;
      imb_fail1 <= imb_bad[0];
      imb_fail2 <= imb_bad[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read, data one cycle after the strobe
  always @(posedge mclk)
  begin
    if (rst)
      rdata <= 32'h00000000;
    else if (rd)
    begin
      if (addr == `REG_CTRL)
        rdata <= {24'h000000, ctrl};
      else if (addr == `REG_UV)
        rdata <= {8'h00, uv_dly, uv_pick, uv_drop};
      else if (addr == `REG_OV)
        rdata <= {5'h00, ov_dly, ov_pick, ov_drop};
      else if (addr == `REG_FREQ)
        rdata <= {6'h00, f_dly, f_drop[2:0], f_band[4:0], nom_f};
      else if (addr == `REG_IMB)
        rdata <= {16'h0000, imb_dly, imb_drop};
      else if (addr == `REG_NOMV)
        rdata <= {16'h0000, nom_v};
      else if (addr == `REG_STATUS)
        rdata <= {23'h000000, rot_bad, imb_bad, fq_bad, ov_bad, uv_bad};
      else
        rdata <= 32'h00000000;
    end
    else
      rdata <= 32'h00000000;
  end

endmodule
`default_nettype wire

// File: logic/srcq_defs.vh
`ifndef SRCQ_DEFS_VH
`define SRCQ_DEFS_VH
// register offsets (word index on the plain port)
`define REG_CTRL      4'h0
`define REG_UV        4'h1
`define REG_OV        4'h2
`define REG_FREQ      4'h3
`define REG_IMB       4'h4
`define REG_NOMV      4'h5
`define REG_STATUS    4'h6
// control register bit positions
`define CTRL_OV_EN1   0
`define CTRL_OV_EN2   1
`define CTRL_FQ_EN1   2
`define CTRL_FQ_EN2   3
`define CTRL_ROT_EN   4
`define CTRL_THREE1   5
`define CTRL_THREE2   6
`define CTRL_FULL     7
`define CTRL_RESET    8'h1F
// reset values: percent, tenths of seconds (imbalance delay in whole seconds), tenths of Hz
`define UV_DROP_RST   8'd90
`define UV_PICK_RST   8'd90
`define UV_DLY_RST    8'd5
`define OV_DROP_RST   8'd110
`define OV_PICK_RST   8'd95
`define OV_DLY_RST    11'd30
`define NOMF_RST      10'd600
`define FBAND_RST     8'd10
`define FDROP_RST     8'd1
`define FDLY_RST      8'd10
`define IMB_DROP_RST  8'd2
`define IMB_DLY_RST   8'd2
`define NOMV_RST      16'd480
// setting ranges
`define UV_DROP_MIN   8'd75
`define UV_DROP_MAX   8'd98
`define UV_PICK_MIN   8'd85
`define UV_PICK_MAX   8'd100
`define UV_DLY_MIN    8'd1
`define UV_DLY_MAX    8'd10
`define OV_DROP_MIN   8'd105
`define OV_DROP_MAX   8'd135
`define OV_PICK_MIN   8'd95
`define OV_PICK_MAX   8'd100
`define OV_DLY_MIN    11'd5
`define OV_DLY_MAX    11'd1200
`define NOMF_MIN      10'd450
`define NOMF_MAX      10'd600
`define FBAND_MIN     8'd5
`define FBAND_MAX     8'd20
`define FDROP_MIN     8'd1
`define FDROP_MAX     8'd5
`define FDLY_MIN      8'd1
`define FDLY_MAX      8'd150
`define IMB_DROP_MIN  8'd2
`define IMB_DROP_MAX  8'd10
`define IMB_DLY_MIN   8'd2
`define IMB_DLY_MAX   8'd20
// timing: one tick each 0.1 s at 125 MHz
`define TICK_NS       100000000
`define CLK_NS        8
`define TICK_CYCLES   (`TICK_NS / `CLK_NS)
`endif

// File: sim/meas_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module meas_front_end (
  // clock
  input wire logic mclk,
  // conditions set by the bench
  input wire logic [15:0] lvl1,
  input wire logic [15:0] skew1,
  input wire logic [9:0] hz1,
  input wire logic on2,
  input wire logic flip2,
  input wire logic slow,
  // measurements
  output logic [47:0] volt1,
  output logic [47:0] volt2,
  output logic [9:0] freq1,
  output logic [9:0] freq2,
  output logic present1,
  output logic present2,
  output logic rot1,
  output logic rot2,
  output logic meas_valid
);
  logic [1:0] pace = 2'h0;
  // slow mode gives one fresh sample in four; a dead source reads zero
  // and its rotation sense wanders rather than holding a stale value
  always @(posedge mclk)
  begin
    pace <= pace + 2'h1;
    meas_valid <= !slow || pace == 2'h0;
    volt1 <= {lvl1 - skew1, lvl1 + skew1, lvl1};
    volt2 <= on2 ? {3{16'h01E0}} : 48'h0;
    freq1 <= hz1;
    freq2 <= on2 ? 10'h258 : 10'h0;
    present1 <= 1'b1;
    present2 <= on2;
    rot1 <= 1'b1;
    rot2 <= on2 ? !flip2 : !rot2;
  end
endmodule
`default_nettype wire

// File: sim/source_qualification_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
module source_qualification_monitor_test;
  localparam int TICK = 10;
  localparam int UV_PICK = 480 * 90 / 100;
  localparam int UV_DROP = UV_PICK * 90 / 100;
  localparam int OV_DROP = 480 * 110 / 100;
  localparam int OV_PICK = OV_DROP * 95 / 100;
  logic mclk, rst, wr, rd, connected2, on2, flip2, slow, ok1;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] lvl1, skew1;
  logic [9:0] hz1, freq1, freq2;
  logic [47:0] volt1, volt2;
  logic present1, present2, rot1, rot2, meas_valid;
  logic avail1, avail2, xfer_req, rexfer_req, xfer_inhibit, imb_fail1, imb_fail2;
  int failures, checked, seed;
  logic [31:0] rst_vals [8] = '{32'h1F, 32'h55A5A, 32'h1E5F6E, 32'h28AA58, 32'h202, 32'h1E0, 0, 0};
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  source_qualification_monitor #(.TICK_COUNT(TICK)) source_qualification_monitor_inst (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .volt1(volt1), .volt2(volt2), .freq1(freq1), .freq2(freq2), .present1(present1),
    .present2(present2), .rot1(rot1), .rot2(rot2), .meas_valid(meas_valid),
    .connected2(connected2), .avail1(avail1), .avail2(avail2), .xfer_req(xfer_req),
    .rexfer_req(rexfer_req), .xfer_inhibit(xfer_inhibit), .imb_fail1(imb_fail1),
    .imb_fail2(imb_fail2));
  meas_front_end meas_front_end_inst (.mclk(mclk), .lvl1(lvl1), .skew1(skew1), .hz1(hz1),
    .on2(on2), .flip2(flip2), .slow(slow), .volt1(volt1), .volt2(volt2), .freq1(freq1),
    .freq2(freq2), .present1(present1), .present2(present2), .rot1(rot1), .rot2(rot2),
    .meas_valid(meas_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // bus cycles: strobes launched and dropped right after rising edges
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  function automatic logic [5:0] outs();
    return {imb_fail1, xfer_inhibit, avail2, rexfer_req, xfer_req, avail1};
  endfunction
  // hysteresis model: a good source fails past drop, a failed one needs pick
  function automatic logic band_ok(input int x, input int drop, input int pick, input logic ok);
    return ok ? x >= drop : x >= pick;
  endfunction
  // output i keeps off v for lo cycles, then reaches v within hi more
  task automatic watch(input int i, input logic v, input int lo, input int hi);
    logic [5:0] o;
    logic early;
    int n;
    early = 1'b0;
    n = 0;
    repeat (lo)
    begin
      @(posedge mclk);
      #1;
      o = outs();
      early = early | (o[i] === v);
    end
    check({31'h0, early}, 32'h0);
    o = outs();
    while (o[i] !== v && n < hi)
    begin
      @(posedge mclk);
      #1;
      o = outs();
      n++;
    end
    if (hi > 0)
    begin
      check({31'h0, o[i]}, {31'h0, v});
      if (o[i] !== v)
        final_report();
    end
  endtask
  // expected avail1 from the model: fail after the delay, recover promptly
  task automatic judge(input int x, input int drop, input int pick, input int dly);
    logic nok;
    nok = band_ok(x, drop, pick, ok1);
    if (nok === ok1)
      watch(0, !ok1, 10 * TICK, 0);
    else if (ok1)
      watch(0, 1'b0, dly * TICK - TICK - 2, 4 * dly * TICK);
    else
      watch(0, 1'b1, 0, 300);
    ok1 = nok;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    checked = 0;
    seed = 70823;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    connected2 = 1'b0;
    on2 = 1'b1;
    flip2 = 1'b0;
    slow = 1'b0;
    skew1 = 16'h0;
    lvl1 = 16'h01E0;
    hz1 = 10'h258;
    ok1 = 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(rdata, rst_vals[0]);
    for (int a = 1; a < 8; a++) reg_rd(4'(a), rst_vals[a]);
    reg_wr(4'h1, 32'h00147832);
    reg_rd(4'h1, 32'h000A644B);
    reg_wr(4'h2, 32'h0);
    reg_rd(4'h2, 32'h00055F69);
    reg_wr(4'h1, rst_vals[1]);
    reg_wr(4'h2, rst_vals[2]);
    // under-voltage with hysteresis
    lvl1 <= 16'(UV_DROP + 10);
    judge(UV_DROP + 10, UV_DROP, UV_PICK, 5);
    lvl1 <= 16'(UV_DROP - 20);
    judge(UV_DROP - 20, UV_DROP, UV_PICK, 5);
    check({31'h0, xfer_req}, 32'h1);
    reg_rd(4'h6, 32'h1);
    lvl1 <= 16'(UV_PICK - 10);
    judge(UV_PICK - 10, UV_DROP, UV_PICK, 5);
    lvl1 <= 16'(445 + ($random(seed) & 31));
    judge(445, UV_DROP, UV_PICK, 5);
    connected2 <= 1'b1;
    watch(2, 1'b1, 0, 20);
    connected2 <= 1'b0;
    // over-voltage, then with the sensor switched off
    lvl1 <= 16'(OV_DROP + 12);
    judge(-(OV_DROP + 12), -OV_DROP, -OV_PICK, 30);
    lvl1 <= 16'(OV_PICK + 10);
    judge(-(OV_PICK + 10), -OV_DROP, -OV_PICK, 30);
    lvl1 <= 16'(450 + ($random(seed) & 31));
    judge(-480, -OV_DROP, -OV_PICK, 30);
    reg_wr(4'h0, 32'h1E);
    lvl1 <= 16'h0230;
    watch(0, 1'b0, 400, 0);
    lvl1 <= 16'h01E0;
    reg_wr(4'h0, 32'h1F);
    // low frequency with a slow front end, then switched off
    slow <= 1'b1;
    hz1 <= 10'd530;
    judge(530, 534, 540, 10);
    hz1 <= 10'd537;
    judge(537, 534, 540, 10);
    hz1 <= 10'(592 + ($random(seed) & 15));
    judge(600, 534, 540, 10);
    slow <= 1'b0;
    reg_wr(4'h0, 32'h1B);
    hz1 <= 10'd520;
    watch(0, 1'b0, 200, 0);
    hz1 <= 10'h258;
    reg_wr(4'h0, 32'h1F);
    // imbalance: silent on single phase, timed on three phase
    skew1 <= 16'd40;
    watch(5, 1'b1, 300, 0);
    reg_wr(4'h0, 32'hBF);
    watch(5, 1'b1, 20 * TICK - TICK - 2, 80 * TICK);
    skew1 <= 16'h0;
    watch(5, 1'b0, 0, 300);
    // rotation
    flip2 <= 1'b1;
    watch(4, 1'b1, 0, 30);
    on2 <= 1'b0;
    watch(4, 1'b0, 0, 30);
    on2 <= 1'b1;
    watch(4, 1'b1, 0, 30);
    reg_wr(4'h0, 32'hAF);
    watch(4, 1'b0, 0, 30);
    flip2 <= 1'b0;
    // three phase source 2 on the reduced level
    reg_wr(4'h0, 32'h1F);
    watch(3, 1'b1, 0, 300);
    reg_wr(4'h0, 32'h5F);
    watch(3, 1'b0, 0, 20);
    watch(3, 1'b1, 300, 0);
    reg_wr(4'h0, 32'hDF);
    watch(3, 1'b1, 0, 300);
    check({31'h0, imb_fail2}, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire

// File: sim/srcq_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module srcq_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // source state
  input wire logic present1,
  input wire logic present2,
  input wire logic rot1,
  input wire logic rot2,
  input wire logic connected2,
  // results
  input wire logic avail2,
  input wire logic xfer_req,
  input wire logic rexfer_req,
  input wire logic xfer_inhibit,
  input wire logic imb_fail1,
  input wire logic imb_fail2
);
  logic [7:0] ctrl;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // mode bits shadowed from writes, so the rules need no internals
  always @(posedge mclk)
  begin
    if (rst)
      ctrl <= 8'h1F;
    else if (wr && addr == 4'h0)
      ctrl <= wdata[7:0];
  end
  ////////////////////////////////////////////////////////////////////////////////
  // enables come up set; read in the first cycle after release
  a_ctrl_reset: assert property ($fell(rst) && rd && addr == 4'h0 |=> rdata[7:0] == 8'h1F)
    else $error("control enables not set after reset");
  a_no_xfer_s2: assert property (connected2 [*4] |-> !xfer_req)
    else $error("transfer asked while on source 2");
  a_no_rexfer_s1: assert property (!connected2 [*4] |-> !rexfer_req)
    else $error("retransfer asked while on source 1");
  a_req_exclusive: assert property (!(xfer_req && rexfer_req))
    else $error("transfer and retransfer together");
  a_single_phase1: assert property ((!ctrl[5]) [*4] |-> !imb_fail1)
    else $error("imbalance on single phase source 1");
  a_single_phase2: assert property ((!ctrl[6]) [*4] |-> !imb_fail2)
    else $error("imbalance on single phase source 2");
  a_reduced_src2: assert property ((ctrl[6] && !ctrl[7]) [*4] |-> !avail2)
    else $error("source 2 available with reduced three phase");
  a_rot_match: assert property ((rot1 == rot2) [*4] |-> !xfer_inhibit)
    else $error("inhibit with matching rotation");
  a_rot_absent: assert property ((!(present1 && present2) || !ctrl[4]) [*4] |-> !xfer_inhibit)
    else $error("inhibit without both sources or with check off");
  // main scenarios reached
  c_xfer: cover property ($rose(xfer_req));
  c_rexfer: cover property ($rose(rexfer_req));
  c_inhibit: cover property ($rose(xfer_inhibit));
  c_imb: cover property ($rose(imb_fail1));
endmodule
bind source_qualification_monitor srcq_checker srcq_checker_inst (.mclk(mclk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .present1(present1),
  .present2(present2), .rot1(rot1), .rot2(rot2), .connected2(connected2), .avail2(avail2),
  .xfer_req(xfer_req), .rexfer_req(rexfer_req), .xfer_inhibit(xfer_inhibit),
  .imb_fail1(imb_fail1), .imb_fail2(imb_fail2));
`default_nettype wire
